// ===== rtl/irap_pkg.sv
// Summary of operation
// [R1] Target never holds the clock line low
// [R2] Controller alone generates SCL for transfers
// [R3] Works with standard, fast, high-speed controllers
// [R4] Address pin strap picks one of four
// [R5] Controller holds SDA 100ns after SCL falls
// [R6] Every transaction opens START, closes STOP
// [R7] First byte: address plus low write bit
// [R8] Second written byte loads 3-bit pointer
// [R9] Third, fourth bytes: selected register MSB, LSB
// [R10] Pointer-only write changes no register
// [R11] Pointer 0 conversion, pointer 1 configuration
// [R12] Read returns selected register, MSB first
// [R13] Input select offers four single-ended inputs
// [R14] Input select offers three inputs against common
// [R15] Acknowledge own address only, else ignore
package irap_pkg;
   localparam int unsigned CLK_HZ        = 40_000_000;
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned SCL_HZ        = 400_000;
   localparam int unsigned QTR_CYC       = CLK_HZ / (4 * SCL_HZ);
   localparam int unsigned SDA_HOLD_NS   = 100;
   localparam int unsigned SDA_HOLD_CYC  = (SDA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0]  PH_HOLD       = 8'(SDA_HOLD_CYC);
   localparam logic [7:0]  PH_RISE       = 8'(2 * QTR_CYC);
   localparam logic [7:0]  PH_SAMP       = 8'(3 * QTR_CYC);
   localparam logic [7:0]  PH_END        = 8'(4 * QTR_CYC - 1);
   localparam logic [3:0]  BIT_ACK       = 4'h8;
   localparam logic [2:0]  BIT_LAST      = 3'h7;
   localparam logic [6:0]  ADDR_BASE     = 7'h48;
   localparam int unsigned NREG          = 8;
   localparam logic [2:0]  PTR_CONV      = 3'h0;
   localparam logic [2:0]  PTR_CONFIG    = 3'h1;
   localparam logic [15:0] REG_RST       = 16'h0000;
   localparam int unsigned INSEL_LSB     = 12;
   localparam int unsigned INSEL_SE_BIT  = 2;
   localparam logic [1:0]  SEL_ZERO      = 2'h0;
   localparam logic [1:0]  SEL_COMMON    = 2'h3;
   localparam logic [1:0]  BYT_PTR       = 2'h0;
   localparam logic [1:0]  BYT_MSB       = 2'h1;
   localparam logic [1:0]  BYT_LSB       = 2'h2;
   localparam logic [1:0]  BYT_FULL      = 2'h3;
   localparam logic [1:0]  LAST_PTR      = 2'h1;
   localparam logic [1:0]  LAST_RD       = 2'h2;
   localparam logic [1:0]  LAST_WR       = 2'h3;
   typedef enum logic [1:0] {OP_PTR, OP_WRITE, OP_READ} irap_op_e;
endpackage

// ===== rtl/irap_if.sv
`timescale 1ns/10ps
interface irap_if;
   logic scl_o;
   logic scl_oe;
   logic sda_o_h;
   logic sda_oe_h;
   logic sda_o_d;
   logic sda_oe_d;
   logic scl;
   logic sda;
   // Open-drain wired AND with pull-ups
   assign scl = ~(scl_oe & ~scl_o);
   assign sda = ~(sda_oe_h & ~sda_o_h) & ~(sda_oe_d & ~sda_o_d);
   modport host   (output scl_o, scl_oe, sda_o_h, sda_oe_h, input scl, sda);
   modport target (output sda_o_d, sda_oe_d, input scl, sda);
endinterface

// ===== rtl/irap_insel.sv
`timescale 1ns/10ps
module irap_insel (
   input  wire logic       clk,        // System clock
   input  wire logic       resetn,     // Synchronous reset, active low
   input  wire logic       ce,         // Clock enable
   input  wire logic [2:0] sel,        // input_select field
   output logic      [1:0] pos_r,      // Positive input choice
   output logic            neg_com_r   // Negative input is common_input
);
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         pos_r     <= irap_pkg::SEL_ZERO;
         neg_com_r <= 1'b1;
      end
      else if (ce)
      begin
         if (sel[irap_pkg::INSEL_SE_BIT])
         begin
            pos_r     <= sel[1:0]; // R13
            neg_com_r <= 1'b0;
         end
         else
         begin
            // Code 3 would pair common_input with itself, so it aliases input_zero
            pos_r     <= (sel[1:0] == irap_pkg::SEL_COMMON) ? irap_pkg::SEL_ZERO : sel[1:0]; // R14
            neg_com_r <= 1'b1;
         end
      end
   end
endmodule

// ===== rtl/irap_target.sv
`timescale 1ns/10ps
module irap_target (
   irap_if.target           BUS,          // I2C pins, target side
   input  wire logic        CLK,          // System clock
   input  wire logic        RESETN,       // Reset, active low; synchronous on system side, asynchronous on link side
   input  wire logic        CE,           // Clock enable, system side
   input  wire logic [1:0]  ADDR_TIE,     // Address pin connection code
   input  wire logic [15:0] CONV_DATA,    // New conversion result
   input  wire logic        CONV_VALID,   // Conversion result strobe
   output logic      [15:0] CONFIG_WORD,  // Configuration register copy
   output logic      [1:0]  POS_SEL,      // Positive input choice
   output logic             NEG_COMMON    // Negative input is common_input
);
   typedef enum logic [2:0] {T_IDLE, T_ADDR, T_ACK_A, T_WR, T_ACK_W, T_RD, T_ACK_R} irap_tst_e;

   irap_tst_e   st_r;
   logic        start_tog_r;
   logic        start_ack_r;
   logic [2:0]  cnt_r;
   logic [7:0]  sh_r;
   logic [1:0]  byt_r;
   logic [2:0]  ptr_r;
   logic [7:0]  hi_r;
   logic [15:0] tx_r;
   logic [15:0] regs_r [0:irap_pkg::NREG-1];
   logic [1:0]  tie1_r;
   logic [1:0]  tie2_r;
   logic        req1_r;
   logic        req2_r;
   logic        ack_r;
   logic        cfg_tog_r;
   logic        oe_r;
   logic        conv_req_r;
   logic [15:0] conv_hold_r;
   logic        ack1_r;
   logic        ack2_r;
   logic        cfg1_r;
   logic        cfg2_r;
   logic        cfg3_r;
   logic [15:0] config_r;

   logic        start_pend;
   logic [7:0]  rx_byte;
   logic [6:0]  my_addr;
   logic        byte_done;
   logic        wr_lsb;
   logic [7:0]  tx_byte;

   assign start_pend = start_tog_r ^ start_ack_r;
   assign rx_byte    = {sh_r[6:0], BUS.sda};
   assign my_addr    = irap_pkg::ADDR_BASE | 7'(tie2_r); // R4
   assign byte_done  = (cnt_r == irap_pkg::BIT_LAST);
   assign wr_lsb     = (st_r == T_WR) && byte_done && (byt_r == irap_pkg::BYT_LSB);
   assign tx_byte    = byt_r[0] ? tx_r[7:0] : tx_r[15:8]; // R12

   // SDA only ever pulled low; SCL is an input only
   assign BUS.sda_o_d  = 1'b0;
   assign BUS.sda_oe_d = oe_r; // R1

   // SCL is stopped through reset and its release, so the link side resets
   // asynchronously; waiting for link edges would leave it unknown at the first START
   // START marker: SDA falling while SCL high
   always_ff @(negedge BUS.sda or negedge RESETN)
   begin
      if (!RESETN)
         start_tog_r <= 1'b0;
      else if (BUS.scl)
         start_tog_r <= ~start_tog_r;
   end

   // Link logic runs on SCL and SDA edges alone, so any controller rate works
   always_ff @(posedge BUS.scl) // R3
   begin
      tie1_r <= ADDR_TIE;
      tie2_r <= tie1_r;
   end

   // START is stable well before the next SCL rise by bus timing
   always_ff @(posedge BUS.scl or negedge RESETN)
   begin
      if (!RESETN)
         start_ack_r <= 1'b0;
      else if (start_pend)
         start_ack_r <= ~start_ack_r;
   end

   always_ff @(posedge BUS.scl or negedge RESETN)
   begin
      if (!RESETN)
      begin
         st_r  <= T_IDLE;
         cnt_r <= 3'h0;
         sh_r  <= 8'h00;
         byt_r <= irap_pkg::BYT_PTR;
         tx_r  <= irap_pkg::REG_RST;
      end
      else if (start_pend)
      begin
         st_r  <= T_ADDR;
         cnt_r <= 3'h1;
         sh_r  <= {7'h00, BUS.sda};
         byt_r <= irap_pkg::BYT_PTR;
      end
      else
      begin
         case (st_r)
            T_ADDR:
            begin
               sh_r  <= rx_byte;
               cnt_r <= cnt_r + 3'h1;
               if (byte_done)
               begin
                  if (sh_r[6:0] == my_addr) // R15
                  begin
                     st_r <= T_ACK_A;
                     tx_r <= BUS.sda ? regs_r[ptr_r] : tx_r; // R12
                  end
                  else
                     st_r <= T_IDLE; // R15
                  sh_r[7] <= BUS.sda; // R7
               end
            end
            T_ACK_A:
            begin
               cnt_r <= 3'h0;
               byt_r <= sh_r[7] ? irap_pkg::BYT_PTR : irap_pkg::BYT_PTR;
               st_r  <= sh_r[7] ? T_RD : T_WR; // R7
            end
            T_WR:
            begin
               sh_r  <= rx_byte;
               cnt_r <= cnt_r + 3'h1;
               if (byte_done)
                  st_r <= (byt_r == irap_pkg::BYT_FULL) ? T_IDLE : T_ACK_W;
            end
            T_ACK_W:
            begin
               cnt_r <= 3'h0;
               byt_r <= byt_r + 2'h1;
               st_r  <= T_WR;
            end
            T_RD:
            begin
               cnt_r <= cnt_r + 3'h1;
               if (byte_done)
                  st_r <= T_ACK_R;
            end
            T_ACK_R:
            begin
               cnt_r <= 3'h0;
               byt_r <= byt_r + 2'h1;
               st_r  <= BUS.sda ? T_IDLE : T_RD; // R12
            end
            default:
               st_r <= T_IDLE;
         endcase
      end
   end

   // Pointer and upper byte capture during a write
   always_ff @(posedge BUS.scl or negedge RESETN)
   begin
      if (!RESETN)
      begin
         ptr_r <= irap_pkg::PTR_CONV;
         hi_r  <= 8'h00;
      end
      else if (!start_pend && (st_r == T_WR) && byte_done)
      begin
         if (byt_r == irap_pkg::BYT_PTR)
            ptr_r <= rx_byte[2:0]; // R8
         if (byt_r == irap_pkg::BYT_MSB)
            hi_r  <= rx_byte; // R9
      end
   end

   // Register file; a host write lands only on a completed LSB byte, so a bare pointer write changes nothing
   always_ff @(posedge BUS.scl or negedge RESETN)
   begin
      if (!RESETN)
      begin
         for (int i = 0; i < irap_pkg::NREG; i++)
            regs_r[i] <= irap_pkg::REG_RST;
         cfg_tog_r <= 1'b0;
      end
      else
      begin
         if (req2_r != ack_r)
            regs_r[irap_pkg::PTR_CONV] <= conv_hold_r; // R11
         if (!start_pend && wr_lsb && (ptr_r != irap_pkg::PTR_CONV)) // R10
            regs_r[ptr_r] <= {hi_r, rx_byte}; // R9
         if (!start_pend && wr_lsb && (ptr_r == irap_pkg::PTR_CONFIG))
            cfg_tog_r <= ~cfg_tog_r; // R11
      end
   end

   // Conversion word handshake, link side
   always_ff @(posedge BUS.scl or negedge RESETN)
   begin
      if (!RESETN)
      begin
         req1_r <= 1'b0;
         req2_r <= 1'b0;
         ack_r  <= 1'b0;
      end
      else
      begin
         req1_r <= conv_req_r;
         req2_r <= req1_r;
         ack_r  <= req2_r;
      end
   end

   // Drive on the falling edge so data is stable across the high phase
   always_ff @(negedge BUS.scl or negedge RESETN)
   begin
      if (!RESETN)
         oe_r <= 1'b0;
      else
      begin
         case (st_r)
            T_ACK_A: oe_r <= 1'b1;
            T_ACK_W: oe_r <= 1'b1;
            T_RD:    oe_r <= ~tx_byte[irap_pkg::BIT_LAST - cnt_r]; // R12
            default: oe_r <= 1'b0;
         endcase
      end
   end

   // System side; a new result is dropped while the last is unclaimed, and
   // the claim only advances while SCL runs, so between frames only the first result is kept
   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         conv_req_r  <= 1'b0;
         conv_hold_r <= irap_pkg::REG_RST;
         ack1_r      <= 1'b0;
         ack2_r      <= 1'b0;
      end
      else if (CE)
      begin
         ack1_r <= ack_r;
         ack2_r <= ack1_r;
         if (CONV_VALID && (conv_req_r == ack2_r))
         begin
            conv_hold_r <= CONV_DATA;
            conv_req_r  <= ~conv_req_r;
         end
      end
   end

   // Config word is quiet for a byte time after its toggle, so a direct copy is safe
   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         cfg1_r   <= 1'b0;
         cfg2_r   <= 1'b0;
         cfg3_r   <= 1'b0;
         config_r <= irap_pkg::REG_RST;
      end
      else if (CE)
      begin
         cfg1_r <= cfg_tog_r;
         cfg2_r <= cfg1_r;
         cfg3_r <= cfg2_r;
         if (cfg2_r != cfg3_r)
            config_r <= regs_r[irap_pkg::PTR_CONFIG]; // R11
      end
   end

   assign CONFIG_WORD = config_r;

   irap_insel u_insel (
      .clk       (CLK),
      .resetn    (RESETN),
      .ce        (CE),
      .sel       (config_r[irap_pkg::INSEL_LSB +: 3]),
      .pos_r     (POS_SEL),
      .neg_com_r (NEG_COMMON)
   );
endmodule

// ===== rtl/irap_ctrl.sv
`timescale 1ns/10ps
module irap_ctrl (
   irap_if.host                BUS,        // I2C pins, controller side
   input  wire logic           CLK,        // System clock
   input  wire logic           RESETN,     // Synchronous reset, active low
   input  wire logic           CE,         // Clock enable
   input  wire logic           CMD_VALID,  // Command request
   output logic                CMD_READY,  // Command accepted when high
   input  irap_pkg::irap_op_e  CMD_OP,     // Pointer, write or read
   input  wire logic [6:0]     CMD_ADDR,   // Target bus address
   input  wire logic [2:0]     CMD_PTR,    // Register pointer
   input  wire logic [15:0]    CMD_DATA,   // Write data
   output logic                RSP_VALID,  // Transaction done pulse
   output logic                RSP_NACK,   // Byte not acknowledged
   output logic      [15:0]    RSP_DATA    // Read data
);
   typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} irap_hst_e;

   irap_hst_e          st_r;
   irap_pkg::irap_op_e op_r;
   logic [6:0]         addr_r;
   logic [2:0]         ptr_r;
   logic [15:0]        data_r;
   logic [7:0]         ph_r;
   logic [3:0]         bit_r;
   logic [1:0]         byt_r;
   logic [1:0]         last_r;
   logic               scl_oe_r;
   logic               sda_oe_r;
   logic               sda1_r;
   logic               sda2_r;
   logic [15:0]        rx_r;
   logic               nack_r;
   logic               rsp_r;
   logic [7:0]         tx_byte;
   logic               rcv;
   logic               drive;

   always_comb
   begin
      case (byt_r)
         irap_pkg::BYT_PTR: tx_byte = {addr_r, op_r == irap_pkg::OP_READ}; // R7
         irap_pkg::BYT_MSB: tx_byte = {5'h00, ptr_r};
         irap_pkg::BYT_LSB: tx_byte = data_r[15:8];
         default:           tx_byte = data_r[7:0];
      endcase
   end

   assign rcv       = (op_r == irap_pkg::OP_READ) && (byt_r != irap_pkg::BYT_PTR);
   // Read: ACK every byte but the last, NACK that one
   assign drive     = (bit_r == irap_pkg::BIT_ACK) ? (rcv && (byt_r != last_r))
                    : (!rcv && !tx_byte[irap_pkg::BIT_LAST - bit_r[2:0]]);
   assign CMD_READY = CE && (st_r == H_IDLE);
   assign RSP_VALID = rsp_r;
   assign RSP_NACK  = nack_r;
   assign RSP_DATA  = rx_r;
   assign BUS.scl_o   = 1'b0;
   assign BUS.scl_oe  = scl_oe_r; // R2
   assign BUS.sda_o_h = 1'b0;
   assign BUS.sda_oe_h = sda_oe_r;

   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         sda1_r <= 1'b1;
         sda2_r <= 1'b1;
      end
      else if (CE)
      begin
         sda1_r <= BUS.sda;
         sda2_r <= sda1_r;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         st_r     <= H_IDLE;
         op_r     <= irap_pkg::OP_PTR;
         addr_r   <= 7'h00;
         ptr_r    <= 3'h0;
         data_r   <= 16'h0000;
         ph_r     <= 8'h00;
         bit_r    <= 4'h0;
         byt_r    <= irap_pkg::BYT_PTR;
         last_r   <= irap_pkg::LAST_PTR;
         scl_oe_r <= 1'b0;
         sda_oe_r <= 1'b0;
         rx_r     <= 16'h0000;
         nack_r   <= 1'b0;
         rsp_r    <= 1'b0;
      end
      else if (CE)
      begin
         rsp_r <= 1'b0;
         ph_r  <= (st_r == H_IDLE || ph_r == irap_pkg::PH_END) ? 8'h00 : ph_r + 8'h01;
         case (st_r)
            H_IDLE:
            begin
               if (CMD_VALID)
               begin
                  st_r   <= H_START;
                  op_r   <= CMD_OP;
                  addr_r <= CMD_ADDR;
                  ptr_r  <= CMD_PTR;
                  data_r <= CMD_DATA;
                  bit_r  <= 4'h0;
                  byt_r  <= irap_pkg::BYT_PTR;
                  nack_r <= 1'b0;
                  case (CMD_OP)
                     irap_pkg::OP_WRITE: last_r <= irap_pkg::LAST_WR;
                     irap_pkg::OP_READ:  last_r <= irap_pkg::LAST_RD;
                     default:            last_r <= irap_pkg::LAST_PTR; // R10
                  endcase
               end
            end
            H_START:
            begin
               if (ph_r == irap_pkg::PH_RISE)
                  sda_oe_r <= 1'b1; // R6
               if (ph_r == irap_pkg::PH_END)
                  st_r <= H_BIT;
            end
            H_BIT:
            begin
               if (ph_r == 8'h00)
                  scl_oe_r <= 1'b1; // R2
               if (ph_r == irap_pkg::PH_HOLD)
                  sda_oe_r <= drive; // R5
               if (ph_r == irap_pkg::PH_RISE)
                  scl_oe_r <= 1'b0;
               if (ph_r == irap_pkg::PH_SAMP)
               begin
                  if (bit_r != irap_pkg::BIT_ACK && rcv)
                     rx_r <= {rx_r[14:0], sda2_r}; // R12
                  if (bit_r == irap_pkg::BIT_ACK && !rcv)
                     nack_r <= nack_r | sda2_r;
               end
               if (ph_r == irap_pkg::PH_END)
               begin
                  if (bit_r != irap_pkg::BIT_ACK)
                     bit_r <= bit_r + 4'h1;
                  else
                  begin
                     bit_r <= 4'h0;
                     byt_r <= byt_r + 2'h1;
                     if (nack_r || byt_r == last_r)
                        st_r <= H_STOP;
                  end
               end
            end
            H_STOP:
            begin
               if (ph_r == 8'h00)
                  scl_oe_r <= 1'b1;
               if (ph_r == irap_pkg::PH_HOLD)
                  sda_oe_r <= 1'b1;
               if (ph_r == irap_pkg::PH_RISE)
                  scl_oe_r <= 1'b0;
               if (ph_r == irap_pkg::PH_SAMP)
                  sda_oe_r <= 1'b0; // R6
               if (ph_r == irap_pkg::PH_END)
               begin
                  st_r  <= H_IDLE;
                  rsp_r <= 1'b1;
               end
            end
            default:
               st_r <= H_IDLE;
         endcase
      end
   end
endmodule

// ===== tb/irap_checker.sv
`timescale 1ns/10ps
module irap_checker (
   input  wire logic CLK,       // System clock
   input  wire logic RESETN,    // Synchronous reset, active low
   input  wire logic scl_o,     // Host SCL drive value
   input  wire logic scl_oe,    // Host SCL pull-down
   input  wire logic sda_o_h,   // Host SDA drive value
   input  wire logic sda_oe_h,  // Host SDA pull-down
   input  wire logic sda_o_d,   // Target SDA drive value
   input  wire logic sda_oe_d,  // Target SDA pull-down
   input  wire logic scl,       // Resolved SCL
   input  wire logic sda        // Resolved SDA
);
   logic armed_r;

   // Target drive is judged only once the host has clocked the bus
   always_ff @(posedge CLK)
   begin
      if (!RESETN)
         armed_r <= 1'h0;
      else if (!scl)
         armed_r <= 1'h1;
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);

   sequence s_start;
      scl && $rose(sda_oe_h);
   endsequence

   sequence s_stop;
      scl && $fell(sda_oe_h);
   endsequence

   property p_scl_free;
      !scl_oe |-> scl;
   endproperty
   property p_od_pins;
      scl_o == 1'h0 && sda_o_h == 1'h0 && sda_o_d == 1'h0;
   endproperty
   property p_sda_hold;
      $fell(scl) |=> $stable(sda_oe_h) [*2];
   endproperty
   property p_start;
      s_start |-> ##[40:60] $fell(scl);
   endproperty
   property p_stop;
      s_stop |=> (scl && sda) [*8];
   endproperty
   property p_low_half;
      $fell(scl) |-> ##[48:52] $rose(scl);
   endproperty
   property p_high_half;
      $rose(scl) |-> scl [*8];
   endproperty
   property p_tgt_edge;
      armed_r && $changed(sda_oe_d) |-> !scl;
   endproperty
   property p_sda_steady;
      armed_r && scl && $past(scl) && $changed(sda) |-> $changed(sda_oe_h);
   endproperty

   a_scl_free: assert property (p_scl_free)
      else $error("SCL held low while host released it");
   a_od_pins: assert property (p_od_pins)
      else $error("open-drain drive value not low");
   a_sda_hold: assert property (p_sda_hold)
      else $error("host SDA changed too soon after SCL fell");
   a_start: assert property (p_start)
      else $error("START not followed by first SCL fall");
   a_stop: assert property (p_stop)
      else $error("bus not idle after STOP");
   a_low_half: assert property (p_low_half)
      else $error("SCL low phase length wrong");
   a_high_half: assert property (p_high_half)
      else $error("SCL high phase too short");
   a_tgt_edge: assert property (p_tgt_edge)
      else $error("target changed SDA while SCL high");
   a_sda_steady: assert property (p_sda_steady)
      else $error("SDA changed during SCL high without host START or STOP");
endmodule

// ===== tb/test_i2c_register_access_port.sv
`timescale 1ns/10ps
module test_i2c_register_access_port;
   logic               CLK        = 1'h0;
   logic               RESETN     = 1'h1;
   logic               CMD_VALID  = 1'h0;
   irap_pkg::irap_op_e CMD_OP     = irap_pkg::OP_PTR;
   logic [6:0]         CMD_ADDR   = 7'h00;
   logic [2:0]         CMD_PTR    = 3'h0;
   logic [15:0]        CMD_DATA   = 16'h0000;
   logic [1:0]         ADDR_TIE   = 2'h0;
   logic [15:0]        CONV_DATA  = 16'h0000;
   logic               CONV_VALID = 1'h0;
   logic               CMD_READY;
   logic               RSP_VALID;
   logic               RSP_NACK;
   logic [15:0]        RSP_DATA;
   logic [15:0]        CONFIG_WORD;
   logic [1:0]         POS_SEL;
   logic               NEG_COMMON;
   logic [15:0]        w;
   logic [6:0]         me;
   int                 err_total  = 0;
   int                 compares   = 0;
   int                 rises      = 0;

   irap_if irap_if_i ();

   irap_target irap_target_i (.BUS(irap_if_i), .CLK(CLK), .RESETN(RESETN), .CE(1'h1),
      .ADDR_TIE(ADDR_TIE), .CONV_DATA(CONV_DATA), .CONV_VALID(CONV_VALID),
      .CONFIG_WORD(CONFIG_WORD), .POS_SEL(POS_SEL), .NEG_COMMON(NEG_COMMON));

   irap_ctrl irap_ctrl_i (.BUS(irap_if_i), .CLK(CLK), .RESETN(RESETN), .CE(1'h1),
      .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD_OP(CMD_OP), .CMD_ADDR(CMD_ADDR),
      .CMD_PTR(CMD_PTR), .CMD_DATA(CMD_DATA), .RSP_VALID(RSP_VALID), .RSP_NACK(RSP_NACK),
      .RSP_DATA(RSP_DATA));

   irap_checker irap_checker_i (.CLK(CLK), .RESETN(RESETN), .scl_o(irap_if_i.scl_o),
      .scl_oe(irap_if_i.scl_oe), .sda_o_h(irap_if_i.sda_o_h), .sda_oe_h(irap_if_i.sda_oe_h),
      .sda_o_d(irap_if_i.sda_o_d), .sda_oe_d(irap_if_i.sda_oe_d), .scl(irap_if_i.scl),
      .sda(irap_if_i.sda));

   always #12.5 CLK = ~CLK;

   // Counting on the wire itself, independent of the host's slot counter
   always @(posedge irap_if_i.scl) rises++;

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic report_and_stop;
      $display("counts: %0d compares, %0d mismatches", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic tick(inout int n, input int lim);
      @(posedge CLK);
      #2;
      n++;
      if (n > lim)
      begin
         err_total++;
         $display("wrong value handshake expected done seen timeout");
         report_and_stop();
      end
   endtask

   task automatic run_cmd(input irap_pkg::irap_op_e op, input logic [6:0] addr,
                          input logic [2:0] ptr, input logic [15:0] data, input logic nack);
      int n;
      int r0;
      int slots;
      n = 0;
      while (CMD_READY !== 1'h1)
         tick(n, 100);
      CMD_OP    = op;
      CMD_ADDR  = addr;
      CMD_PTR   = ptr;
      CMD_DATA  = data;
      CMD_VALID = 1'h1;
      r0        = rises;
      tick(n, 200);
      CMD_VALID = 1'h0;
      n = 0;
      while (RSP_VALID !== 1'h1)
         tick(n, 5000);
      slots = (op == irap_pkg::OP_PTR) ? 20 : (op == irap_pkg::OP_WRITE) ? 38 : 29;
      if (nack)
         slots = 11;
      chk("ack", 16'(RSP_NACK), 16'(nack));
      chk("scl rises", 16'(rises - r0), 16'(slots - 1));
   endtask

   initial
   begin
      // Reset falls after time zero so the link side sees a real edge
      #1;
      RESETN = 1'h0;
      repeat (2) @(posedge CLK);
      #2;
      RESETN = 1'h1;
      for (int c = 0; c < 4; c++)
      begin
         ADDR_TIE = 2'(c);
         run_cmd(irap_pkg::OP_PTR, irap_pkg::ADDR_BASE | 7'(c), irap_pkg::PTR_CONFIG,
                 16'h0000, 1'h0);
         run_cmd(irap_pkg::OP_PTR, irap_pkg::ADDR_BASE | 7'((c + 1) % 4),
                 irap_pkg::PTR_CONFIG, 16'h0000, 1'h1);
      end
      $display("test address done");
      me = irap_pkg::ADDR_BASE | 7'h03;
      for (int s = 0; s < 8; s++)
      begin
         w = 16'h0583 | (16'(s) << irap_pkg::INSEL_LSB);
         run_cmd(irap_pkg::OP_WRITE, me, irap_pkg::PTR_CONFIG, w, 1'h0);
         chk("config word", CONFIG_WORD, w);
         chk("pos select", 16'(POS_SEL), (s >= 4) ? 16'(s - 4) : (s == 3) ? 16'h0 : 16'(s));
         chk("neg common", 16'(NEG_COMMON), (s < 4) ? 16'h1 : 16'h0);
      end
      run_cmd(irap_pkg::OP_READ, me, irap_pkg::PTR_CONFIG, 16'h0000, 1'h0);
      chk("config read", RSP_DATA, w);
      $display("test config done");
      run_cmd(irap_pkg::OP_WRITE, me, 3'h2, 16'h1234, 1'h0);
      run_cmd(irap_pkg::OP_WRITE, me, 3'h3, 16'hABCD, 1'h0);
      run_cmd(irap_pkg::OP_PTR, me, 3'h2, 16'hFFFF, 1'h0);
      chk("config kept", CONFIG_WORD, w);
      run_cmd(irap_pkg::OP_READ, me, 3'h0, 16'h0000, 1'h0);
      chk("pointer read", RSP_DATA, 16'h1234);
      $display("test pointer done");
      @(posedge CLK);
      #2;
      CONV_DATA  = 16'h5A5A;
      CONV_VALID = 1'h1;
      @(posedge CLK);
      #2;
      CONV_VALID = 1'h0;
      run_cmd(irap_pkg::OP_PTR, me, irap_pkg::PTR_CONV, 16'h0000, 1'h0);
      run_cmd(irap_pkg::OP_WRITE, me, irap_pkg::PTR_CONV, 16'hFFFF, 1'h0);
      run_cmd(irap_pkg::OP_READ, me, 3'h0, 16'h0000, 1'h0);
      chk("conversion read", RSP_DATA, 16'h5A5A);
      $display("test conversion done");
      report_and_stop();
   end
endmodule
